// ### ast_pkg.sv
package ast_pkg;

    localparam int DATA_W    = 9;
    localparam int TXQ_DEPTH = 4;
    localparam int RXQ_DEPTH = 4;
    localparam int QCNT_W    = 3;
    localparam int BAUD_W    = 16;

    // 16 baud ticks make one bit time; receiver samples on tick 7
    localparam logic [3:0] OVS_LAST = 4'hF;
    localparam logic [3:0] OVS_MID  = 4'h7;

    localparam logic [3:0] BITS_8 = 4'h7;
    localparam logic [3:0] BITS_9 = 4'h8;

    // frame format encodings
    localparam logic [1:0] FMT_8N = 2'h0;
    localparam logic [1:0] FMT_8E = 2'h1;
    localparam logic [1:0] FMT_8O = 2'h2;
    localparam logic [1:0] FMT_9N = 2'h3;

    // receive interrupt select encodings, fill levels before the push, and the transmit fill level before the pop
    localparam logic [1:0] RXI_FILL3 = 2'h2;
    localparam logic [1:0] RXI_FILL4 = 2'h3;
    localparam logic [2:0] LVL_PRE3  = 3'h2;
    localparam logic [2:0] LVL_PRE4  = 3'h3;
    localparam logic [2:0] LVL_LAST  = 3'h1;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_START = 3'b001,
        ST_DATA  = 3'b010,
        ST_PAR   = 3'b011,
        ST_STOP  = 3'b100,
        ST_WAITH = 3'b101
    } ast_state_t;

    typedef struct packed {
        logic              parity_err_flag;
        logic              framing_err_flag;
        logic [DATA_W-1:0] data;
    } ast_rx_word_t;

endpackage : ast_pkg

// ### ast_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module ast_fifo #(
    parameter int W     = 9,
    parameter int DEPTH = 4
) (
    input  wire logic                         i_clock,
    input  wire logic                         i_nrst,
    input  wire logic                         i_flush,
    input  wire logic                         i_in_valid,
    output logic                              o_in_ready,
    input  wire logic [W-1:0]                 i_in_data,
    output logic                              o_out_valid,
    input  wire logic                         i_out_ready,
    output logic [W-1:0]                      o_out_data,
    output logic [$clog2(DEPTH+1)-1:0]        o_count
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic          push;
    logic          pop;

    // a refused push leaves pointers and contents untouched
    assign o_in_ready  = (o_count != CW'(DEPTH));
    assign o_out_valid = (o_count != '0);
    assign push        = i_in_valid & o_in_ready;
    assign pop         = o_out_valid & i_out_ready;
    assign o_out_data  = mem[rd_ptr];

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            wr_ptr  <= '0;
            rd_ptr  <= '0;
            o_count <= '0;
        end else if (i_flush) begin
            wr_ptr  <= '0;
            rd_ptr  <= '0;
            o_count <= '0;
        end else begin
            if (push)
                wr_ptr <= AW'(wr_ptr + 1'b1);
            if (pop)
                rd_ptr <= AW'(rd_ptr + 1'b1);
            if (push && !pop)
                o_count <= CW'(o_count + 1'b1);
            else if (pop && !push)
                o_count <= CW'(o_count - 1'b1);
        end
    end

    always_ff @(posedge i_clock) begin
        if (push)
            mem[wr_ptr] <= i_in_data;
    end

endmodule : ast_fifo

`default_nettype wire

// ### ast_uart.sv
// What this block does
// - enable owns pins; line idles high; reset disables
// - disable flushes FIFOs, baud counter, aborts transfers
// - disable clears status flags, sets idle flags
// - alternate select moves both pins to alternates
// - frame format and stop count; default 8N1
// - load shifter at once; enable restarts baud
// - four-deep transmit FIFO with full indication
// - write to full transmit FIFO is dropped
// - both FIFOs cleared by reset or disable
// - transmit interrupt per pop or on empty
// - break forces line low, no interrupt
// - read pops FIFO, error flags follow head
// - four-deep receive FIFO, avail flag, empty-read harmless
// - receive interrupt per push or fill level
// - overrun when full; reception halts until cleared
// - framing error if any stop bit low
// - parity error only in parity formats
// - idle flag low from start to stop
// - long break gives zero word, waits high
// - address words always interrupt in address mode
// - tick every divisor plus one clocks
`timescale 1ns/1ps
`default_nettype none

module ast_uart (
    input  wire logic        i_clock,
    input  wire logic        i_nrst,
    input  wire logic        i_module_enable,
    input  wire logic        i_alt_pin_select,
    input  wire logic [1:0]  i_frame_format_sel,
    input  wire logic        i_stop_count_sel,
    input  wire logic [15:0] i_baud_divisor,
    input  wire logic        i_tx_enable_bit,
    input  wire logic        i_break_send,
    input  wire logic        i_tx_irq_select,
    input  wire logic [1:0]  i_rx_irq_select,
    input  wire logic        i_addr_detect_enable,
    input  wire logic        i_tx_write,
    input  wire logic [15:0] i_tx_data_port,
    input  wire logic        i_rx_read,
    input  wire logic        i_overrun_clear,
    input  wire logic        i_serial_in_pin,
    input  wire logic        i_alt_serial_in_pin,
    output logic             o_serial_out_pin,
    output logic             o_serial_out_oe,
    output logic             o_alt_serial_out_pin,
    output logic             o_alt_serial_out_oe,
    output logic [8:0]       o_rx_data_port,
    output logic             o_rx_data_avail,
    output logic             o_overrun_flag,
    output logic             o_framing_err_flag,
    output logic             o_parity_err_flag,
    output logic             o_rx_idle_flag,
    output logic             o_tx_fifo_full,
    output logic             o_tx_shifter_empty,
    output logic             o_tx_irq_flag,
    output logic             o_rx_irq_flag
);
    logic                          en;
    logic                          tx_en;
    logic                          tx_en_d;
    logic                          tx_en_rise;
    logic                          brk;
    logic                          nine_bit;
    logic                          has_par;
    logic [3:0]                    last_bit;
    logic [ast_pkg::BAUD_W-1:0]    baud_cnt;
    logic                          tick;

    logic                          txq_ready;
    logic                          txq_valid;
    logic                          txq_pop;
    logic [ast_pkg::DATA_W-1:0]    txq_data;
    logic [ast_pkg::QCNT_W-1:0]    txq_count;
    ast_pkg::ast_state_t           tx_state;
    logic [3:0]                    tx_sub;
    logic [3:0]                    tx_bit;
    logic [ast_pkg::DATA_W-1:0]    tx_shift;
    logic                          tx_par;
    logic                          tx_stopn;
    logic                          tx_line;

    logic                          rx_in;
    ast_pkg::ast_state_t           rx_state;
    logic [3:0]                    rx_sub;
    logic [3:0]                    rx_bit;
    logic [ast_pkg::DATA_W-1:0]    rx_shift;
    logic                          rx_framing_err_flag;
    logic                          rx_parity_err_flag;
    logic                          rx_stopn;
    logic                          rx_done;
    logic                          framing_err_flag_now;
    logic                          rx_push;
    ast_pkg::ast_rx_word_t         rx_word;
    logic                          rxq_ready;
    logic                          rxq_valid;
    logic                          rxq_pop;
    ast_pkg::ast_rx_word_t         rxq_head;
    logic [ast_pkg::QCNT_W-1:0]    rxq_count;
    logic                          rx_accept;
    logic                          overrun;

    assign en         = i_module_enable;
    assign tx_en      = en & i_tx_enable_bit;
    assign tx_en_rise = tx_en & ~tx_en_d;
    assign brk        = en & i_break_send;
    assign nine_bit   = (i_frame_format_sel == ast_pkg::FMT_9N);
    assign has_par    = (i_frame_format_sel == ast_pkg::FMT_8E) ||
                        (i_frame_format_sel == ast_pkg::FMT_8O);
    assign last_bit   = nine_bit ? ast_pkg::BITS_9 : ast_pkg::BITS_8;

    // ---------------- baud tick ----------------
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst)
            tx_en_d <= 1'b0;
        else
            tx_en_d <= tx_en;
    end

    // restarting from zero on enable lets a preloaded word leave promptly
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            baud_cnt <= '0;
            tick     <= 1'b0;
        end else if (!en || tx_en_rise) begin
            baud_cnt <= '0;
            tick     <= 1'b0;
        end else if (baud_cnt >= i_baud_divisor) begin
            baud_cnt <= '0;
            tick     <= 1'b1;
        end else begin
            baud_cnt <= ast_pkg::BAUD_W'(baud_cnt + 1'b1);
            tick     <= 1'b0;
        end
    end

    // ---------------- transmit path ----------------
    ast_fifo #(
        .W     (ast_pkg::DATA_W),
        .DEPTH (ast_pkg::TXQ_DEPTH)
    ) u_txq (
        .i_clock     (i_clock),
        .i_nrst      (i_nrst),
        .i_flush     (!en),
        .i_in_valid  (i_tx_write),
        .o_in_ready  (txq_ready),
        .i_in_data   (i_tx_data_port[ast_pkg::DATA_W-1:0]),
        .o_out_valid (txq_valid),
        .i_out_ready (txq_pop),
        .o_out_data  (txq_data),
        .o_count     (txq_count)
    );

    assign txq_pop = tx_en && (tx_state == ast_pkg::ST_IDLE) && txq_valid;

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            tx_state <= ast_pkg::ST_IDLE;
            tx_sub   <= '0;
            tx_bit   <= '0;
            tx_shift <= '0;
            tx_par   <= 1'b0;
            tx_stopn <= 1'b0;
            tx_line  <= 1'b1;
        end else if (!en) begin
            tx_state <= ast_pkg::ST_IDLE;
            tx_sub   <= '0;
            tx_line  <= 1'b1;
        end else if (txq_pop) begin
            tx_state <= ast_pkg::ST_START;
            tx_sub   <= '0;
            tx_bit   <= '0;
            tx_stopn <= 1'b0;
            tx_shift <= nine_bit ? txq_data : {1'b0, txq_data[7:0]};
            tx_par   <= (^txq_data[7:0]) ^ (i_frame_format_sel == ast_pkg::FMT_8O);
        end else if (tick && tx_state != ast_pkg::ST_IDLE) begin
            tx_sub <= 4'(tx_sub + 1'b1);
            // the line changes only on a tick, so the start bit waits for one
            if (tx_sub == '0) begin
                unique case (tx_state)
                    ast_pkg::ST_START: tx_line <= 1'b0;
                    ast_pkg::ST_DATA:  tx_line <= tx_shift[0];
                    ast_pkg::ST_PAR:   tx_line <= tx_par;
                    default:           tx_line <= 1'b1;
                endcase
            end
            if (tx_sub == ast_pkg::OVS_LAST) begin
                unique case (tx_state)
                    ast_pkg::ST_START: tx_state <= ast_pkg::ST_DATA;
                    ast_pkg::ST_DATA: begin
                        tx_shift <= tx_shift >> 1;
                        tx_bit   <= 4'(tx_bit + 1'b1);
                        if (tx_bit == last_bit)
                            tx_state <= has_par ? ast_pkg::ST_PAR : ast_pkg::ST_STOP;
                    end
                    ast_pkg::ST_PAR: tx_state <= ast_pkg::ST_STOP;
                    default: begin
                        if (i_stop_count_sel && !tx_stopn)
                            tx_stopn <= 1'b1;
                        else
                            tx_state <= ast_pkg::ST_IDLE;
                    end
                endcase
            end
        end
    end

    // pins: enable takes the pin chosen by alternate select; break overrides whatever is shifting
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_serial_out_pin     <= 1'b1;
            o_serial_out_oe      <= 1'b0;
            o_alt_serial_out_pin <= 1'b1;
            o_alt_serial_out_oe  <= 1'b0;
        end else begin
            o_serial_out_oe      <= en && !i_alt_pin_select;
            o_alt_serial_out_oe  <= en && i_alt_pin_select;
            o_serial_out_pin     <= !(en && !i_alt_pin_select) || (tx_line && !brk);
            o_alt_serial_out_pin <= !(en && i_alt_pin_select) || (tx_line && !brk);
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_tx_fifo_full     <= 1'b0;
            o_tx_shifter_empty <= 1'b1;
            o_tx_irq_flag      <= 1'b0;
        end else begin
            o_tx_fifo_full     <= en && !txq_ready;
            o_tx_shifter_empty <= (tx_state == ast_pkg::ST_IDLE) && !txq_pop;
            o_tx_irq_flag      <= txq_pop &&
                                  (!i_tx_irq_select || txq_count == ast_pkg::LVL_LAST);
        end
    end

    // ---------------- receive path ----------------
    assign rx_in    = i_alt_pin_select ? i_alt_serial_in_pin : i_serial_in_pin;
    assign framing_err_flag_now = rx_framing_err_flag || !rx_in;
    assign rx_done  = tick && rx_sub == ast_pkg::OVS_MID &&
                      rx_state == ast_pkg::ST_STOP && !(i_stop_count_sel && !rx_stopn);

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            rx_state       <= ast_pkg::ST_IDLE;
            rx_sub         <= '0;
            rx_bit         <= '0;
            rx_shift       <= '0;
            rx_framing_err_flag        <= 1'b0;
            rx_parity_err_flag        <= 1'b0;
            rx_stopn       <= 1'b0;
            o_rx_idle_flag <= 1'b1;
        end else if (!en) begin
            rx_state       <= ast_pkg::ST_IDLE;
            o_rx_idle_flag <= 1'b1;
        end else if (rx_state == ast_pkg::ST_IDLE) begin
            if (!rx_in && !overrun) begin
                rx_state       <= ast_pkg::ST_START;
                rx_sub         <= '0;
                rx_bit         <= '0;
                rx_framing_err_flag        <= 1'b0;
                rx_parity_err_flag        <= 1'b0;
                rx_stopn       <= 1'b0;
                o_rx_idle_flag <= 1'b0;
            end
        end else if (rx_state == ast_pkg::ST_WAITH) begin
            if (rx_in)
                rx_state <= ast_pkg::ST_IDLE;
        end else if (tick) begin
            rx_sub <= 4'(rx_sub + 1'b1);
            if (rx_sub == ast_pkg::OVS_MID) begin
                unique case (rx_state)
                    ast_pkg::ST_START: begin
                        // a high sample here was a glitch, not a start bit
                        if (rx_in) begin
                            rx_state       <= ast_pkg::ST_IDLE;
                            o_rx_idle_flag <= 1'b1;
                        end else
                            rx_state <= ast_pkg::ST_DATA;
                    end
                    ast_pkg::ST_DATA: begin
                        rx_shift <= nine_bit ? {rx_in, rx_shift[8:1]}
                                             : {1'b0, rx_in, rx_shift[7:1]};
                        rx_bit   <= 4'(rx_bit + 1'b1);
                        if (rx_bit == last_bit)
                            rx_state <= has_par ? ast_pkg::ST_PAR : ast_pkg::ST_STOP;
                    end
                    ast_pkg::ST_PAR: begin
                        rx_parity_err_flag  <= rx_in ^ (^rx_shift[7:0]) ^
                                    (i_frame_format_sel == ast_pkg::FMT_8O);
                        rx_state <= ast_pkg::ST_STOP;
                    end
                    default: begin
                        rx_framing_err_flag <= framing_err_flag_now;
                        if (i_stop_count_sel && !rx_stopn)
                            rx_stopn <= 1'b1;
                        else begin
                            o_rx_idle_flag <= 1'b1;
                            // a held-low line must rise before a new start counts
                            rx_state <= rx_in ? ast_pkg::ST_IDLE : ast_pkg::ST_WAITH;
                        end
                    end
                endcase
            end
        end
    end

    // the word is pushed one cycle after its last stop sample
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            rx_push <= 1'b0;
            rx_word <= '0;
        end else begin
            rx_push      <= en && rx_done && rxq_ready;
            rx_word.data <= rx_shift;
            rx_word.framing_err_flag <= framing_err_flag_now;
            rx_word.parity_err_flag <= rx_parity_err_flag && has_par;
        end
    end

    // only a pop can change the fill level meanwhile, so the push never stalls
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst)
            overrun <= 1'b0;
        else if (!en)
            overrun <= 1'b0;
        else if (rx_done && !rxq_ready)
            overrun <= 1'b1;
        else if (i_overrun_clear)
            overrun <= 1'b0;
    end

    ast_fifo #(
        .W     ($bits(ast_pkg::ast_rx_word_t)),
        .DEPTH (ast_pkg::RXQ_DEPTH)
    ) u_rxq (
        .i_clock     (i_clock),
        .i_nrst      (i_nrst),
        .i_flush     (!en),
        .i_in_valid  (rx_push),
        .o_in_ready  (rxq_ready),
        .i_in_data   (rx_word),
        .o_out_valid (rxq_valid),
        .i_out_ready (rxq_pop),
        .o_out_data  (rxq_head),
        .o_count     (rxq_count)
    );

    assign rxq_pop   = i_rx_read && rxq_valid;
    assign rx_accept = rx_push && rxq_ready;

    // status shows the head word; an empty FIFO leaves the old value readable
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rx_data_port     <= '0;
            o_framing_err_flag <= 1'b0;
            o_parity_err_flag  <= 1'b0;
            o_rx_data_avail    <= 1'b0;
            o_overrun_flag     <= 1'b0;
        end else begin
            o_rx_data_avail <= en && rxq_valid;
            o_overrun_flag  <= en && (overrun || (rx_done && !rxq_ready));
            if (!en) begin
                o_framing_err_flag <= 1'b0;
                o_parity_err_flag  <= 1'b0;
            end else if (rxq_valid) begin
                o_rx_data_port     <= rxq_head.data;
                o_framing_err_flag <= rxq_head.framing_err_flag;
                o_parity_err_flag  <= rxq_head.parity_err_flag;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst)
            o_rx_irq_flag <= 1'b0;
        else if (!rx_accept)
            o_rx_irq_flag <= 1'b0;
        else if (i_addr_detect_enable && nine_bit)
            o_rx_irq_flag <= rx_word.data[8];
        else if (i_rx_irq_select == ast_pkg::RXI_FILL3)
            o_rx_irq_flag <= (rxq_count == ast_pkg::LVL_PRE3);
        else if (i_rx_irq_select == ast_pkg::RXI_FILL4)
            o_rx_irq_flag <= (rxq_count == ast_pkg::LVL_PRE4);
        else
            o_rx_irq_flag <= 1'b1;
    end

endmodule : ast_uart

`default_nettype wire

// ### ast_chk.sv
`timescale 1ns/1ps
`default_nettype none
module ast_chk (
    input wire logic       i_clock, i_nrst, i_module_enable, i_alt_pin_select, i_break_send,
    input wire logic       i_tx_write, i_addr_detect_enable, i_overrun_clear, i_serial_in_pin,
    input wire logic       i_alt_serial_in_pin, o_serial_out_pin, o_serial_out_oe,
    input wire logic       o_alt_serial_out_oe, o_rx_data_avail, o_overrun_flag, o_rx_idle_flag,
    input wire logic       o_tx_fifo_full, o_tx_shifter_empty, o_rx_irq_flag,
    input wire logic [1:0] i_rx_irq_select
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_nrst);
    wire logic rx_line = i_alt_pin_select ? i_alt_serial_in_pin : i_serial_in_pin;
    property p_idle_high; o_tx_shifter_empty && !$past(i_break_send) |-> o_serial_out_pin; endproperty
    a_idle_high: assert property (p_idle_high) else $error("line low while idle");
    property p_off; !$past(i_module_enable) && !$past(i_module_enable, 2) |-> !o_serial_out_oe
        && !o_alt_serial_out_oe && !o_rx_data_avail && !o_tx_fifo_full && !o_overrun_flag
        && o_rx_idle_flag && o_tx_shifter_empty; endproperty
    a_off: assert property (p_off) else $error("flags wrong while disabled");
    property p_brk; $past(i_break_send) && $past(i_module_enable) && !$past(i_alt_pin_select)
        |-> !o_serial_out_pin; endproperty
    a_brk: assert property (p_brk) else $error("break not low");
    property p_alt; $past(i_module_enable) && $past(i_alt_pin_select)
        |-> o_alt_serial_out_oe && !o_serial_out_oe; endproperty
    a_alt: assert property (p_alt) else $error("wrong pin driven");
    property p_start; $fell(o_rx_idle_flag) |-> !$past(rx_line); endproperty
    a_start: assert property (p_start) else $error("busy without start");
    property p_full; $rose(o_tx_fifo_full) |-> $past(i_tx_write) || $past(i_tx_write, 2); endproperty
    a_full: assert property (p_full) else $error("full without write");
    property p_ovr; o_overrun_flag && !i_overrun_clear && !$past(i_overrun_clear)
        && i_module_enable |=> o_overrun_flag; endproperty
    a_ovr: assert property (p_ovr) else $error("overrun lost");
    // the receive pulse leads the available flag by one cycle
    property p_rxi; $rose(o_rx_data_avail) && $past(i_rx_irq_select) == 2'h0
        && !$past(i_addr_detect_enable) |-> $past(o_rx_irq_flag); endproperty
    a_rxi: assert property (p_rxi) else $error("no receive event");
endmodule : ast_chk
bind ast_uart ast_chk i_ast_chk (.*);
`default_nettype wire

// ### ast_peer.sv
`timescale 1ns/1ps
`default_nettype none
module ast_peer (
    input  wire logic i_clock,
    input  wire logic i_line,
    output var logic  o_line
);
    initial o_line = 1'b1;
    // w carries data, parity and stop levels lsb first; a low stop makes a framing fault
    task automatic send(input logic [11:0] w, input int n);
        for (int b = 0; b <= n; b++) begin
            o_line = (b == 0) ? 1'b0 : w[b-1];
            repeat (16) @(negedge i_clock);
        end
        o_line = 1'b1;
    endtask : send
    task automatic recv(output logic [8:0] d, input int n);
        d = '0;
        @(negedge i_line);
        repeat (8) @(posedge i_clock);
        for (int b = 0; b < n; b++) begin
            repeat (16) @(posedge i_clock);
            d[b] = i_line;
        end
    endtask : recv
endmodule : ast_peer
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic i_clock, i_nrst, i_module_enable, i_alt_pin_select, i_stop_count_sel, i_tx_enable_bit;
    logic i_break_send, i_tx_irq_select, i_addr_detect_enable, i_tx_write, i_rx_read;
    logic i_overrun_clear, i_serial_in_pin, i_alt_serial_in_pin, o_serial_out_pin;
    logic o_serial_out_oe, o_alt_serial_out_pin, o_alt_serial_out_oe, o_rx_data_avail;
    logic o_overrun_flag, o_framing_err_flag, o_parity_err_flag, o_rx_idle_flag;
    logic o_tx_fifo_full, o_tx_shifter_empty, o_tx_irq_flag, o_rx_irq_flag;
    logic [1:0]  i_frame_format_sel, i_rx_irq_select;
    logic [15:0] i_baud_divisor, i_tx_data_port;
    logic [8:0]  o_rx_data_port, got;
    int          err_total, checks, tx_irqs, rx_irqs;
    ast_uart i_ast_uart (.*);
    ast_peer i_ast_peer (.i_clock(i_clock), .i_line(o_serial_out_pin), .o_line(i_serial_in_pin));
    // each irq pulse stands one cycle, so one falling edge sees it once
    always @(negedge i_clock) begin
        tx_irqs += int'(o_tx_irq_flag === 1'b1);
        rx_irqs += int'(o_rx_irq_flag === 1'b1);
    end
    initial begin
        i_clock = 1'b0;
        forever #20 i_clock = ~i_clock;
    end
    task automatic check(input string n, input logic [8:0] s, input logic [8:0] e);
        checks++;
        if (s !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(negedge i_clock);
    endtask : tick
    task automatic wr(input logic [15:0] v);
        tick(1);
        i_tx_data_port = v;
        i_tx_write = 1'b1;
        tick(1);
        i_tx_write = 1'b0;
    endtask : wr
    // data port lags a pop by one cycle, so each read waits it out
    task automatic rd();
        tick(1);
        i_rx_read = 1'b1;
        tick(1);
        i_rx_read = 1'b0;
        tick(2);
    endtask : rd
    task automatic rx(input logic [11:0] w, input int n);
        i_ast_peer.send(w, n);
        for (int k = 0; k < 400 && o_rx_data_avail !== 1'b1; k++) tick(1);
        tick(3);
    endtask : rx
    task automatic stop_test();
        $display("mismatches %0d comparisons %0d", err_total, checks);
        if (err_total == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : stop_test
    initial begin
        {i_nrst, i_module_enable, i_alt_pin_select, i_stop_count_sel, i_tx_enable_bit} = '0;
        {i_break_send, i_tx_irq_select, i_addr_detect_enable, i_tx_write, i_rx_read} = '0;
        {i_overrun_clear, i_frame_format_sel, i_rx_irq_select, i_baud_divisor} = '0;
        {i_tx_data_port, i_alt_serial_in_pin} = 17'h00001;
        repeat (3) @(posedge i_clock);
        tick(1);
        i_nrst = 1'b1;
        check("idle", {o_rx_idle_flag, o_tx_shifter_empty, o_serial_out_pin, o_serial_out_oe}, 9'h00E);
        i_module_enable = 1'b1;
        i_alt_pin_select = 1'b1;
        for (int k = 1; k < 6; k++) wr(16'h0011 * k);
        tick(1);
        check("full", o_tx_fifo_full, 9'h001);
        check("alt", {o_alt_serial_out_pin, o_alt_serial_out_oe, o_serial_out_oe}, 9'h006);
        i_alt_pin_select = 1'b0;
        i_tx_enable_bit = 1'b1;
        for (int k = 1; k < 5; k++) begin
            i_ast_peer.recv(got, 8);
            check("tx", got, 9'h011 * k);
        end
        tick(60);
        check("tx end", o_tx_shifter_empty, 9'h001);
        i_break_send = 1'b1;
        tick(2);
        check("break", o_serial_out_pin, 9'h000);
        tick(16 * 13);
        i_break_send = 1'b0;
        tick(32);
        check("txirq", tx_irqs[8:0], 9'h004);
        rx({1'b1, 8'h3C}, 9);
        check("rx", o_rx_data_port, 9'h03C);
        rd();
        rx({1'b0, 8'h81}, 9);
        check("framing_err_flag", o_framing_err_flag, 9'h001);
        rd();
        check("avail", o_rx_data_avail, 9'h000);
        rd();
        check("old", o_rx_data_port, 9'h081);
        i_frame_format_sel = ast_pkg::FMT_8E;
        rx({2'b11, 8'h5A}, 10);
        check("parity_err_flag", o_parity_err_flag, 9'h001);
        rd();
        i_frame_format_sel = ast_pkg::FMT_8O;
        i_stop_count_sel = 1'b1;
        rx({3'b011, 8'h5A}, 11);
        check("stop2", {o_framing_err_flag, o_parity_err_flag}, 9'h002);
        rd();
        i_stop_count_sel = 1'b0;
        i_frame_format_sel = ast_pkg::FMT_8N;
        for (int k = 0; k < 5; k++) rx({1'b1, k[7:0]}, 9);
        check("ovr", o_overrun_flag, 9'h001);
        for (int k = 0; k < 4; k++) begin
            check("head", o_rx_data_port, k[8:0]);
            rd();
        end
        check("drop", o_rx_data_avail, 9'h000);
        i_overrun_clear = 1'b1;
        tick(1);
        i_overrun_clear = 1'b0;
        tick(2);
        check("ovr clr", o_overrun_flag, 9'h000);
        i_frame_format_sel = ast_pkg::FMT_9N;
        i_addr_detect_enable = 1'b1;
        i_rx_irq_select = ast_pkg::RXI_FILL3;
        rx({1'b1, 9'h1A5}, 10);
        rx({1'b1, 9'h0A5}, 10);
        check("addr", o_rx_data_port, 9'h1A5);
        check("rxirq", rx_irqs[8:0], 9'h009);
        i_tx_irq_select = 1'b1;
        repeat (3) wr(16'h0055);
        tick(400);
        check("txirq sel", tx_irqs[8:0], 9'h006);
        i_tx_enable_bit = 1'b0;
        repeat (4) wr(16'h0099);
        i_module_enable = 1'b0;
        tick(3);
        check("flush", {o_tx_fifo_full, o_rx_data_avail, o_overrun_flag}, 9'h000);
        stop_test();
    end
    initial begin
        repeat (20000) @(posedge i_clock);
        err_total++;
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
